// [hdl/latch_ack_map.svh]
// register offsets, field positions, widths and reset values of the acknowledge block
`ifndef LATCH_ACK_MAP_SVH
`define LATCH_ACK_MAP_SVH

// ==================================================
// sizes
`define LA_NUM_RELAY      8
`define LA_NUM_SCADA      8
`define LA_NUM_SWGR       4
`define LA_LEDS_PER_GRP   7
`define LA_NUM_LED        14
`define LA_NUM_EXT        6
`define LA_NUM_IRQ        4
`define LA_ADDR_W         8
`define LA_DATA_W         32

// ==================================================
// register byte offsets
`define LA_REG_LED_MODE_A 8'h00
`define LA_REG_LED_MODE_B 8'h04
`define LA_REG_LATCH_STAT 8'h08
`define LA_REG_LED_STAT   8'h0c
`define LA_REG_IRQ_STAT   8'h10
`define LA_REG_IRQ_CLEAR  8'h14
`define LA_REG_IRQ_ENABLE 8'h18

// ==================================================
// field positions
`define LA_STAT_RELAY_LSB 0
`define LA_STAT_SCADA_LSB 8
`define LA_STAT_SWGR_LSB  16
`define LA_EXT_RELAY_BIT  0
`define LA_EXT_SCADA_BIT  1
`define LA_EXT_SWGR_LSB   2
`define LA_IRQ_RELAY_BIT  0
`define LA_IRQ_SCADA_BIT  1
`define LA_IRQ_SWGR_BIT   2
`define LA_IRQ_AUTO_BIT   3

// ==================================================
// reset values
`define LA_RST_IRQ_EN     4'h0

`endif

// [hdl/latch_ack_pkg.sv]
// types shared by the acknowledge block
package latch_ack_pkg;
  typedef enum logic [1:0] {
    LED_PLAIN       = 2'b00,
    LED_LATCH       = 2'b01,
    LED_LATCH_ALARM = 2'b10,
    LED_LATCH_SPARE = 2'b11
  } led_mode_t;
endpackage

// [hdl/sync_if.sv]
// interface carrying pin levels into the synchroniser and clean levels and edges back
`timescale 1ns/10ps
`default_nettype none
interface sync_if #(parameter int W = 6);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  logic [W-1:0] rise;
  modport sync (input raw, output level, output rise);
  modport user (output raw, input level, input rise);
endinterface
`default_nettype wire

// [hdl/input_sync.sv]
// three-stage pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/10ps
`default_nettype none
module input_sync #(
  parameter int W = 6
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // pins in, clean levels and edges out
  sync_if.sync      sif
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, rise_q;
  logic [W-1:0] lvl_d, rise_d;

  // ==================================================
  // filter: a change counts once stages two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
    end
    rise_d = lvl_d & ~lvl_q;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      lvl_q  <= '0;
      rise_q <= '0;
    end else begin
      s1_q   <= sif.raw;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      lvl_q  <= lvl_d;
      rise_q <= rise_d;
    end
  end

  assign sif.level = lvl_q;
  assign sif.rise  = rise_q;
endmodule
`default_nettype wire

// [hdl/latch_acknowledge_logic.sv]
// latched relay, scada, trip and led indications with external and automatic acknowledge
`timescale 1ns/10ps
`default_nettype none
`include "latch_ack_map.svh"

// Function
// - A rising external relay-acknowledge input clears every latched output relay together.
// - A rising external scada-acknowledge input clears every latched scada signal.
// - A rising protection alarm clears each led set to latch with alarm acknowledge.
// - The alarm acknowledge choice is a separate mode setting for each led.
// - There are two led groups of seven leds, each with a latch mode including ack by alarm.
module latch_acknowledge_logic
  import latch_ack_pkg::*;
(
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         resetn,
  // register port
  input  wire logic [`LA_ADDR_W-1:0]        addr,
  input  wire logic [`LA_DATA_W-1:0]        wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  output logic      [`LA_DATA_W-1:0]        rdata,
  // acknowledge pins
  input  wire logic                         output_relay_ack_input,
  input  wire logic                         scada_ack_input,
  input  wire logic [`LA_NUM_SWGR-1:0]      switchgear_instance_ack_input,
  // set requests and alarm from protection logic
  input  wire logic [`LA_NUM_RELAY-1:0]     relay_set,
  input  wire logic [`LA_NUM_SCADA-1:0]     scada_set,
  input  wire logic [`LA_NUM_SWGR-1:0]      trip_set,
  input  wire logic [`LA_NUM_LED-1:0]       led_src,
  input  wire logic                         prot_alarm,
  // latched indications and interrupt
  output logic      [`LA_NUM_RELAY-1:0]     relay_out,
  output logic      [`LA_NUM_SCADA-1:0]     scada_out,
  output logic      [`LA_NUM_SWGR-1:0]      trip_out,
  output logic      [`LA_NUM_LED-1:0]       led_out,
  output logic                              irq
);

  // ==================================================
  // helpers
  function automatic logic [`LA_DATA_W-1:0] pack_modes(
    input led_mode_t m [`LA_NUM_LED], input int base);
    logic [`LA_DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < `LA_LEDS_PER_GRP; i++) begin
      r[2*i +: 2] = m[base + i];
    end
    return r;
  endfunction

  function automatic logic is_latched(input led_mode_t m);
    return m != LED_PLAIN;
  endfunction

  // ==================================================
  // pin synchroniser
  sync_if #(.W(`LA_NUM_EXT)) ext_if ();
  assign ext_if.raw = {switchgear_instance_ack_input, scada_ack_input, output_relay_ack_input};

  input_sync #(.W(`LA_NUM_EXT)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .sif    (ext_if)
  );

  logic                     ack_relay, ack_scada, alarm_rise;
  logic [`LA_NUM_SWGR-1:0]  ack_swgr;
  assign ack_relay = ext_if.rise[`LA_EXT_RELAY_BIT];
  assign ack_scada = ext_if.rise[`LA_EXT_SCADA_BIT];
  assign ack_swgr  = ext_if.rise[`LA_EXT_SWGR_LSB +: `LA_NUM_SWGR];

  // ==================================================
  // state
  logic [`LA_NUM_RELAY-1:0] relay_q, relay_d;
  logic [`LA_NUM_SCADA-1:0] scada_q, scada_d;
  logic [`LA_NUM_SWGR-1:0]  trip_q, trip_d;
  logic [`LA_NUM_LED-1:0]   led_q, led_d;
  led_mode_t                mode_q [`LA_NUM_LED];
  led_mode_t                mode_d [`LA_NUM_LED];
  logic                     alarm_q;
  logic [`LA_NUM_IRQ-1:0]   ist_q, ist_d, ien_q, ien_d, iev;
  logic                     irq_q, irq_d;
  logic [`LA_DATA_W-1:0]    rdata_q, rdata_d;

  assign alarm_rise = prot_alarm & ~alarm_q;

  // ==================================================
  // latches: a set in the clearing cycle wins over the clear
  always_comb begin
    relay_d = relay_set | (ack_relay ? '0 : relay_q);
    scada_d = scada_set | (ack_scada ? '0 : scada_q);
    trip_d  = trip_set | (trip_q & ~ack_swgr);
    for (int i = 0; i < `LA_NUM_LED; i++) begin
      if (!is_latched(mode_q[i])) begin
        led_d[i] = led_src[i];
      end else if (mode_q[i] == LED_LATCH_ALARM && alarm_rise) begin
        led_d[i] = led_src[i];
      end else begin
        led_d[i] = led_src[i] | led_q[i];
      end
    end
  end

  // ==================================================
  // register writes, interrupt status and reads
  always_comb begin
    mode_d = mode_q;
    ien_d  = ien_q;
    if (wr && addr == `LA_REG_LED_MODE_A) begin
      for (int i = 0; i < `LA_LEDS_PER_GRP; i++) begin
        mode_d[i] = led_mode_t'(wdata[2*i +: 2]);
      end
    end
    if (wr && addr == `LA_REG_LED_MODE_B) begin
      for (int i = 0; i < `LA_LEDS_PER_GRP; i++) begin
        mode_d[`LA_LEDS_PER_GRP + i] = led_mode_t'(wdata[2*i +: 2]);
      end
    end
    if (wr && addr == `LA_REG_IRQ_ENABLE) begin
      ien_d = wdata[`LA_NUM_IRQ-1:0];
    end
    iev = '0;
    iev[`LA_IRQ_RELAY_BIT] = ack_relay;
    iev[`LA_IRQ_SCADA_BIT] = ack_scada;
    iev[`LA_IRQ_SWGR_BIT]  = |ack_swgr;
    iev[`LA_IRQ_AUTO_BIT]  = alarm_rise;
    // an event in the clearing cycle stays set
    ist_d = ist_q;
    if (wr && addr == `LA_REG_IRQ_CLEAR) begin
      ist_d = ist_q & ~wdata[`LA_NUM_IRQ-1:0];
    end
    ist_d = ist_d | iev;
    irq_d = |(ist_d & ien_d);
    rdata_d = '0;
    if (rd) begin
      case (addr)
        `LA_REG_LED_MODE_A: rdata_d = pack_modes(mode_q, 0);
        `LA_REG_LED_MODE_B: rdata_d = pack_modes(mode_q, `LA_LEDS_PER_GRP);
        `LA_REG_LATCH_STAT: begin
          rdata_d[`LA_STAT_RELAY_LSB +: `LA_NUM_RELAY] = relay_q;
          rdata_d[`LA_STAT_SCADA_LSB +: `LA_NUM_SCADA] = scada_q;
          rdata_d[`LA_STAT_SWGR_LSB +: `LA_NUM_SWGR]   = trip_q;
        end
        `LA_REG_LED_STAT:   rdata_d[`LA_NUM_LED-1:0] = led_q;
        `LA_REG_IRQ_STAT:   rdata_d[`LA_NUM_IRQ-1:0] = ist_q;
        `LA_REG_IRQ_ENABLE: rdata_d[`LA_NUM_IRQ-1:0] = ien_q;
        default:            rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      relay_q <= '0;
      scada_q <= '0;
      trip_q  <= '0;
      led_q   <= '0;
      alarm_q <= 1'b0;
      for (int i = 0; i < `LA_NUM_LED; i++) begin
        mode_q[i] <= LED_PLAIN;
      end
      ist_q   <= '0;
      ien_q   <= `LA_RST_IRQ_EN;
      irq_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      relay_q <= relay_d;
      scada_q <= scada_d;
      trip_q  <= trip_d;
      led_q   <= led_d;
      alarm_q <= prot_alarm;
      mode_q  <= mode_d;
      ist_q   <= ist_d;
      ien_q   <= ien_d;
      irq_q   <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  assign relay_out = relay_q;
  assign scada_out = scada_q;
  assign trip_out  = trip_q;
  assign led_out   = led_q;
  assign irq       = irq_q;
  assign rdata     = rdata_q;

  // ==================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence relay_ack_seq;
    ack_relay && relay_q != '0;
  endsequence

  relay_clear_a: assert property (relay_ack_seq |=> relay_q == $past(relay_set))
    else $error("relay latch not cleared by acknowledge");
  scada_clear_a: assert property (ack_scada |=> scada_q == $past(scada_set))
    else $error("scada latch not cleared by acknowledge");
  for (genvar g = 0; g < `LA_NUM_LED; g++) begin : g_led_chk
    led_auto_a: assert property (
      (alarm_rise && mode_q[g] == LED_LATCH_ALARM && !led_src[g]) |=> !led_q[g])
      else $error("alarm did not clear led");
    led_keep_a: assert property (
      (led_q[g] && mode_q[g] == LED_LATCH) |=> led_q[g])
      else $error("latched led lost without alarm mode");
    led_plain_a: assert property (
      (mode_q[g] == LED_PLAIN) |=> led_q[g] == $past(led_src[g]))
      else $error("plain led does not follow source");
  end
  for (genvar s = 0; s < `LA_NUM_SWGR; s++) begin : g_trip_chk
    trip_only_a: assert property (
      (trip_q[s] && !ack_swgr[s]) |=> trip_q[s])
      else $error("trip cleared by another instance");
    trip_clear_a: assert property (
      (ack_swgr[s] && !trip_set[s]) |=> !trip_q[s])
      else $error("trip not cleared by own acknowledge");
  end
  irq_level_a: assert property (irq == (|(ist_q & ien_q)))
    else $error("interrupt level does not match enabled status");

endmodule
`default_nettype wire

// [tb/latch_acknowledge_logic_tb.sv]
// self-checking bench for the latched indication acknowledge block
`timescale 1ns/10ps
`default_nettype none
`include "latch_ack_map.svh"
module latch_acknowledge_logic_tb
  import latch_ack_pkg::*;
;
  // ==================================================
  // stimulus and observed signals
  logic                     clk;
  logic                     resetn;
  logic [`LA_ADDR_W-1:0]    addr;
  logic [`LA_DATA_W-1:0]    wdata;
  logic                     wr;
  logic                     rd;
  logic [`LA_DATA_W-1:0]    rdata;
  logic [`LA_NUM_EXT-1:0]   ext;
  logic [`LA_NUM_RELAY-1:0] relay_set;
  logic [`LA_NUM_SCADA-1:0] scada_set;
  logic [`LA_NUM_SWGR-1:0]  trip_set;
  logic [`LA_NUM_LED-1:0]   led_src;
  logic                     prot_alarm;
  logic [`LA_NUM_RELAY-1:0] relay_out;
  logic [`LA_NUM_SCADA-1:0] scada_out;
  logic [`LA_NUM_SWGR-1:0]  trip_out;
  logic [`LA_NUM_LED-1:0]   led_out;
  logic                     irq;
  int                       err_count;
  int                       checks_done;

  latch_acknowledge_logic dut_u (
    .clk                           (clk),
    .resetn                        (resetn),
    .addr                          (addr),
    .wdata                         (wdata),
    .wr                            (wr),
    .rd                            (rd),
    .rdata                         (rdata),
    .output_relay_ack_input        (ext[`LA_EXT_RELAY_BIT]),
    .scada_ack_input               (ext[`LA_EXT_SCADA_BIT]),
    .switchgear_instance_ack_input (ext[`LA_EXT_SWGR_LSB +: `LA_NUM_SWGR]),
    .relay_set                     (relay_set),
    .scada_set                     (scada_set),
    .trip_set                      (trip_set),
    .led_src                       (led_src),
    .prot_alarm                    (prot_alarm),
    .relay_out                     (relay_out),
    .scada_out                     (scada_out),
    .trip_out                      (trip_out),
    .led_out                       (led_out),
    .irq                           (irq)
  );

  // ==================================================
  // shared tasks
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  // pin clears land five edges after the rise; the pin then drops long enough to re-arm
  task automatic pulse_ack(input int b);
    @(posedge clk);
    ext[b] <= 1'b1;
    repeat (7) @(posedge clk);
    ext[b] <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic set_all();
    @(posedge clk);
    relay_set <= 8'hff;
    scada_set <= 8'hff;
    trip_set  <= 4'hf;
    @(posedge clk);
    relay_set <= 8'h00;
    scada_set <= 8'h00;
    trip_set  <= 4'h0;
    @(posedge clk);
    #1;
  endtask

  // ==================================================
  // scenarios
  task automatic t_relay();
    logic [31:0] d;
    set_all();
    chk(relay_out, 8'hff, "relay set");
    wr_reg(`LA_REG_IRQ_ENABLE, 32'h1);
    pulse_ack(`LA_EXT_RELAY_BIT);
    chk(relay_out, 8'h00, "relay ack");
    chk(scada_out, 8'hff, "scada kept");
    chk(irq, 1'b1, "irq raised");
    wr_reg(`LA_REG_IRQ_CLEAR, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b0, "irq cleared");
    rd_reg(`LA_REG_IRQ_ENABLE, d);
    chk(d, 32'h1, "irq enable readback");
    @(posedge clk);
    #1 chk(rdata, 32'h0, "read data one cycle only");
    $display("test relay done");
  endtask

  task automatic t_scada_trip();
    logic [31:0] d;
    pulse_ack(`LA_EXT_SCADA_BIT);
    chk(scada_out, 8'h00, "scada ack");
    chk(trip_out, 4'hf, "trip kept");
    pulse_ack(`LA_EXT_SWGR_LSB + 2);
    chk(trip_out, 4'hb, "trip ack one");
    rd_reg(`LA_REG_LATCH_STAT, d);
    chk(d, 32'h000b0000, "latch status");
    $display("test scada and trip done");
  endtask

  task automatic t_led();
    logic [31:0] d;
    // group a: led1 ack by alarm, led2 latched with no auto ack; group b: led7 ack by alarm
    wr_reg(`LA_REG_LED_MODE_A, 32'he);
    wr_reg(`LA_REG_LED_MODE_B, 32'h2000);
    rd_reg(`LA_REG_LED_MODE_A, d);
    chk(d, 32'he, "mode a readback");
    rd_reg(`LA_REG_LED_MODE_B, d);
    chk(d, 32'h2000, "mode b readback");
    @(posedge clk);
    led_src <= 14'h2003;
    @(posedge clk);
    led_src <= 14'h0000;
    repeat (2) @(posedge clk);
    #1 chk(led_out, 14'h2003, "leds latched");
    @(posedge clk);
    prot_alarm <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(led_out, 14'h0002, "alarm ack");
    rd_reg(`LA_REG_IRQ_STAT, d);
    chk(d, 32'he, "irq status");
    rd_reg(`LA_REG_LED_STAT, d);
    chk(d, 32'h0002, "led status");
    // group a led3 stays plain and must follow its source both ways
    @(posedge clk);
    led_src <= 14'h0004;
    @(posedge clk);
    #1 chk(led_out, 14'h0006, "plain led follows high");
    @(posedge clk);
    led_src <= 14'h0000;
    @(posedge clk);
    #1 chk(led_out, 14'h0002, "plain led follows low");
    $display("test led done");
  endtask

  task automatic t_reset();
    logic [31:0] d;
    @(posedge clk);
    resetn     <= 1'b0;
    prot_alarm <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(led_out, 14'h0000, "leds cleared in reset");
    chk(trip_out, 4'h0, "trip cleared in reset");
    @(posedge clk);
    resetn <= 1'b1;
    rd_reg(`LA_REG_LED_MODE_A, d);
    chk(d, 32'h0, "mode after second reset");
    chk(irq, 1'b0, "irq after second reset");
    $display("test mid-run reset done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==================================================
  // main sequence
  initial begin
    logic [31:0] d;
    err_count   = 0;
    checks_done = 0;
    resetn      = 1'b0;
    addr        = 8'h00;
    wdata       = 32'h0;
    wr          = 1'b0;
    rd          = 1'b0;
    ext         = 6'h00;
    relay_set   = 8'h00;
    scada_set   = 8'h00;
    trip_set    = 4'h0;
    led_src     = 14'h0000;
    prot_alarm  = 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rd_reg(`LA_REG_LED_MODE_A, d);
    chk(d, 32'h0, "mode reset");
    rd_reg(8'h3c, d);
    chk(d, 32'h0, "unmapped read");
    t_relay();
    t_scada_trip();
    t_led();
    t_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
